// >>> lpnp_top.sv
// Partner next page register, control register and receive error shaping
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`include "lpnp_defs.svh"

// ==========================================
// Symbol FIFO
module lpnp_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // Drain side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } lpnp_fifo_st_t;
  lpnp_fifo_st_t            st;
  lpnp_fifo_st_t            next_st;
  logic [WIDTH-1:0]         mem [DEPTH];
  logic                     push;
  logic                     pop;

  assign in_ready_o  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st.cnt != '0);
  assign out_data_o  = mem[st.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
    end
    if (pop)
    begin
      next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
    if (push)
    begin
      mem[st.wp] <= in_data_i;
    end
  end
endmodule

// ==========================================
// Top
module lpnp_top #(
  parameter int FIFO_DEPTH = `LPNP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Received next page from negotiation logic
  input  wire logic        page_valid_i,
  input  wire logic [15:0] page_word_i,
  // Receive symbol stream from line decoder
  input  wire logic        sym_valid_i,
  input  wire logic        sym_active_i,
  input  wire logic        sym_false_car_i,
  input  wire logic        sym_err_i,
  input  wire logic [1:0]  sym_data_i,
  output logic             sym_ready_o,
  // RMII receive toward MAC
  output logic             crs_dv_o,
  output logic             rx_er_o,
  output logic [1:0]       rxd_o,
  // Mode status
  output logic             enh_mode_o
);
  typedef struct packed {
    logic [15:0]        page;
    logic               enh;
    lpnp_pkg::lpnp_rx_t rx;
    logic               err_seen;
    logic               ack;
    logic [31:0]        rdat;
    logic               crs_dv;
    logic               rx_er;
    logic [1:0]         rxd;
  } lpnp_st_t;
  lpnp_st_t     st;
  lpnp_st_t     next_st;
  logic [4:0]   f_data;
  logic         f_valid;
  logic         f_act;
  logic         f_fc;
  logic         f_se;
  logic [1:0]   f_d;
  logic [3:0]   idx;
  logic         req;

  // Drained one per cycle unconditionally; register accesses never stall the decoder
  lpnp_fifo #(
    .WIDTH(5),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .in_data_i  ({sym_active_i, sym_false_car_i, sym_err_i, sym_data_i}),
    .in_valid_i (sym_valid_i),
    .in_ready_o (sym_ready_o),
    .out_data_o (f_data),
    .out_valid_o(f_valid),
    .out_ready_i(1'b1)
  );
  assign {f_act, f_fc, f_se, f_d} = f_data;
  assign idx = adr_i[`LPNP_ADDR_LSB+3:`LPNP_ADDR_LSB];
  assign req = cyc_i && stb_i && !st.ack;

  always_comb
  begin
    next_st = st;
    next_st.ack = req;
    if (page_valid_i)
    begin
      next_st.page = page_word_i;
    end
    if (req)
    begin
      next_st.rdat = '0;
      case (idx)
        `LPNP_IDX_PAGE: next_st.rdat[15:0] = st.page;
        `LPNP_IDX_CTRL: next_st.rdat[`LPNP_BIT_ENH] = st.enh;
        default:        next_st.rdat = '0;
      endcase
      if (we_i && sel_i[1] && idx == `LPNP_IDX_CTRL)
      begin
        next_st.enh = dat_i[`LPNP_BIT_ENH];
      end
    end
    if (f_valid)
    begin
      next_st.rx_er = 1'b0;
      if (!f_act)
      begin
        next_st.rx       = lpnp_pkg::LPNP_IDLE;
        next_st.err_seen = 1'b0;
        next_st.crs_dv   = 1'b0;
        next_st.rxd      = '0;
      end
      else
      begin
        case (st.rx)
          lpnp_pkg::LPNP_IDLE,
          lpnp_pkg::LPNP_DATA:
          begin
            next_st.crs_dv = 1'b1;
            next_st.rx     = lpnp_pkg::LPNP_DATA;
            next_st.rxd    = f_d;
            if (f_fc && st.rx == lpnp_pkg::LPNP_IDLE)
            begin
              next_st.rx     = st.enh ? lpnp_pkg::LPNP_DROP : lpnp_pkg::LPNP_FCAR;
              next_st.crs_dv = !st.enh;
              next_st.rx_er  = !st.enh;
              next_st.rxd    = st.enh ? 2'h0 : `LPNP_FC_CODE;
            end
            else if (f_se && st.enh)
            begin
              next_st.rx     = lpnp_pkg::LPNP_DROP;
              next_st.crs_dv = 1'b0;
              next_st.rxd    = '0;
            end
            else if (f_se || st.err_seen)
            begin
              next_st.err_seen = 1'b1;
              next_st.rx_er    = f_se;
              next_st.rxd      = `LPNP_ERR_DATA;
            end
          end
          lpnp_pkg::LPNP_FCAR:
          begin
            next_st.rx_er = 1'b1;
            next_st.rxd   = `LPNP_FC_CODE;
          end
          lpnp_pkg::LPNP_DROP:
          begin
            next_st.crs_dv = 1'b0;
            next_st.rxd    = '0;
          end
          default: next_st.rx = lpnp_pkg::LPNP_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st      <= '0;
      st.page <= {5'h00, `LPNP_CODE_RST};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign dat_o      = st.rdat;
  assign ack_o      = st.ack;
  assign crs_dv_o   = st.crs_dv;
  assign rx_er_o    = st.rx_er;
  assign rxd_o      = st.rxd;
  assign enh_mode_o = st.enh;
endmodule

// >>> lpnp_defs.svh
// Constants for partner next page and receive error control block
// Functional notes
// - Bit 15 shows partner wants to send more next pages
// - Bit 14 shows partner acknowledged the link code word
// - Bit 13 shows message page (1) or unformatted page (0)
// - Bit 12 shows partner can comply with the message
// - Bit 11 shows partner toggle, inverse of previous word's toggle
// - Bits 10:0 hold received 11-bit message or unformatted code
// - After reset code reads 1 (null page), flags read 0
// - Control bit 9 read-write, reset 0, selects enhanced receive error mode
// - Carrier/data-valid asserted whenever receive line is not idle; enhanced mode drops it on false carrier or at a symbol error
// - Normal mode false carrier: error high, data 10 until event ends
// - Enhanced mode false carrier: drop carrier/data-valid for rest of event
// - Normal mode: start intact, error per symbol error, data ones after first
// - Enhanced mode: drop carrier/data-valid at first symbol error
`ifndef LPNP_DEFS_SVH
`define LPNP_DEFS_SVH
// ==========================================
// Register map (word index, byte address is index times four)
`define LPNP_IDX_PAGE      4'h8
`define LPNP_IDX_CTRL      4'h9
`define LPNP_ADDR_LSB      2
// ==========================================
// Field positions and resets
`define LPNP_BIT_NP        15
`define LPNP_BIT_ACK       14
`define LPNP_BIT_MP        13
`define LPNP_BIT_ACK2      12
`define LPNP_BIT_TOG       11
`define LPNP_CODE_RST      11'h001
`define LPNP_BIT_ENH       9
`define LPNP_FC_CODE       2'h2
`define LPNP_ERR_DATA      2'h3
`define LPNP_FIFO_DEPTH    8
`endif

// >>> lpnp_pkg.sv
// Types for partner next page and receive error control block
package lpnp_pkg;
  typedef enum logic [1:0] {
    LPNP_IDLE = 2'h0,
    LPNP_DATA = 2'h1,
    LPNP_FCAR = 2'h3,
    LPNP_DROP = 2'h2
  } lpnp_rx_t;
endpackage

// >>> lpnp_mac_model.sv
// Behavioural MAC receive sink counting data-valid beats
`timescale 1ns/1ps
// ==========================================
// MAC sink
module lpnp_mac_model (
  input wire logic       clk_i,
  input wire logic       crs_dv_i,
  input wire logic       rx_er_i,
  input wire logic [1:0] rxd_i
);
  int beats = 0;
  int errs  = 0;
  // Sampled on the edge like a real RMII receiver
  always @(posedge clk_i)
  begin
    beats <= beats + int'(crs_dv_i);
    errs  <= errs + int'(rx_er_i);
  end
endmodule

// >>> lpnp_chk.sv
// Assertion checker for the partner page and receive control block
`timescale 1ns/1ps
// ==========================================
// Checker
module lpnp_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        crs_dv_o,
  input wire logic        rx_er_o,
  input wire logic [1:0]  rxd_o,
  input wire logic        enh_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence ctrl_wr;
    wb_req ##0 (we_i && sel_i[1] && adr_i[5:2] == 4'h9);
  endsequence
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (wb_req |=> ack_o)
    else $error("no ack");
  a_enh_write: assert property (ctrl_wr |=> enh_mode_o == $past(dat_i[9]))
    else $error("mode bit not written");
  a_ctrl_read: assert property (ack_o && !$past(we_i) && $past(adr_i[5:2]) == 4'h9
    |-> dat_o[15:9] == {6'h00, enh_mode_o})
    else $error("control read wrong");
  a_fc_hold: assert property (!enh_mode_o && crs_dv_o && rx_er_o && rxd_o == 2'h2
    |=> !crs_dv_o || (rx_er_o && rxd_o == 2'h2))
    else $error("false carrier not held");
  a_err_ones: assert property (!enh_mode_o && crs_dv_o && rx_er_o && rxd_o == 2'h3
    |=> !crs_dv_o || rxd_o == 2'h3)
    else $error("data not ones after error");
  a_enh_drop: assert property (enh_mode_o && !crs_dv_o |-> rxd_o == 2'h0)
    else $error("dropped data not zero");
  a_reset_vals: assert property ($fell(rst_i) |-> !ack_o && !enh_mode_o && !crs_dv_o)
    else $error("reset values wrong");
endmodule
bind lpnp_top lpnp_chk chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .dat_o, .ack_o, .crs_dv_o, .rx_er_o, .rxd_o, .enh_mode_o);

// >>> tb.sv
// Self-checking bench for the partner page and receive control block
`timescale 1ns/1ps
// ==========================================
// Bench
module tb;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        page_valid_i = 0, sym_valid_i = 0, sym_active_i = 0, sym_err_i = 0;
  logic        sym_false_car_i = 0, sym_ready_o, crs_dv_o, rx_er_o, enh_mode_o;
  logic [15:0] page_word_i = 16'h0, pg;
  logic [1:0]  sym_data_i = 2'h0, rxd_o;
  int          err_total = 0, tests_run = 0, b0;
  lpnp_top dut (.*);
  lpnp_mac_model mac (.clk_i, .crs_dv_i(crs_dv_o), .rx_er_i(rx_er_o), .rxd_i(rxd_o));
  initial
    forever #5 clk_i = ~clk_i;
  task automatic results;
    $display("tests %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded waits end the run
  task automatic tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      err_total++;
      results;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n = 0;
    cyc_i <= 1;
    stb_i <= 1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1 && ++n < 20);
    tmo(ack_o);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic sym(input logic act, fc, er, input logic [1:0] d);
    int n = 0;
    sym_valid_i     <= 1;
    sym_active_i    <= act;
    sym_false_car_i <= fc;
    sym_err_i       <= er;
    sym_data_i      <= d;
    // Ready is judged at the very edge that takes the symbol
    do
      @(posedge clk_i);
    while (sym_ready_o !== 1'b1 && ++n < 20);
    tmo(sym_ready_o);
  endtask
  // Errors at ep and ep+2 show rxd stays ones in between
  task automatic frame(input int n, input logic fc, input int ep);
    for (int i = 0; i < n; i++)
      sym(1, fc && i == 0, i == ep || i == ep + 2, 2'($urandom));
    sym(0, 0, 0, 2'h0);
    sym_valid_i <= 0;
    repeat (4) @(posedge clk_i);
  endtask
  initial
  begin
    b0 = $urandom(25);
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h20, 0, 4'hF);
    chk(rd, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      pg = i < 5 ? 16'h8000 >> i : 16'($urandom);
      page_word_i  <= pg;
      page_valid_i <= 1;
      @(posedge clk_i);
      page_valid_i <= 0;
      wb(1, 8'h20, {16'h0, ~pg}, 4'hF);
      wb(0, 8'h20, 0, 4'hF);
      chk(rd, {16'h0, pg});
    end
    wb(1, 8'h24, 32'hFFFF_FFFF, 4'hD);
    wb(0, 8'h24, 0, 4'hF);
    chk(rd, 32'h0);
    wb(1, 8'h24, 32'hFFFF_FFFF, 4'hF);
    wb(0, 8'h24, 0, 4'hF);
    chk(rd, 32'h200);
    chk(32'(enh_mode_o), 32'h1);
    wb(0, 8'h3C, 0, 4'hF);
    chk(rd, 32'h0);
    b0 = mac.beats;
    frame(6, 1, 99);
    chk(32'(mac.beats - b0), 32'h0);
    b0 = mac.beats;
    frame(6, 0, 2);
    chk(32'(mac.beats - b0), 32'h2);
    wb(1, 8'h24, 32'h0, 4'hF);
    b0 = mac.beats;
    frame(5, 0, 99);
    chk(32'(mac.beats - b0), 32'h5);
    b0 = mac.errs;
    frame(6, 1, 99);
    chk(32'(mac.errs - b0), 32'h6);
    b0 = mac.errs;
    frame(6, 0, 1);
    chk(32'(mac.errs - b0), 32'h2);
    for (int k = 0; k < 6; k++)
      frame(3 + $urandom % 5, 1'($urandom), $urandom % 6);
    wb(1, 8'h24, 32'h200, 4'hF);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h24, 0, 4'hF);
    chk(rd, 32'h0);
    results;
  end
endmodule
